// file: vtr_pkg.sv
// Constants for the VLAN table read port: register indices, entry layout,
// command fields and reset values.
// Assumes a 32-bit APB slave whose register index times four is the byte address.
package vtr_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] VTR_IDX_CMD    = 16'h180B;
  localparam logic [15:0] VTR_IDX_WDATA  = 16'h180D;
  localparam logic [15:0] VTR_IDX_RESULT = 16'h180E;
  localparam logic [15:0] VTR_IDX_STATUS = 16'h1810;
  localparam logic [15:0] VTR_IDX_CFG    = 16'h1812;
  localparam int          VTR_AW         = 16;
  localparam logic [VTR_AW-1:0] VTR_ADDR_CMD    = {VTR_IDX_CMD[13:0], 2'b00};
  localparam logic [VTR_AW-1:0] VTR_ADDR_WDATA  = {VTR_IDX_WDATA[13:0], 2'b00};
  localparam logic [VTR_AW-1:0] VTR_ADDR_RESULT = {VTR_IDX_RESULT[13:0], 2'b00};
  localparam logic [VTR_AW-1:0] VTR_ADDR_STATUS = {VTR_IDX_STATUS[13:0], 2'b00};
  localparam logic [VTR_AW-1:0] VTR_ADDR_CFG    = {VTR_IDX_CFG[13:0], 2'b00};

  // ----------------------------------------------------------------
  // Table entry layout
  // ----------------------------------------------------------------
  localparam int VTR_ENTRY_W    = 18;
  localparam int VTR_VID_LSB    = 0;
  localparam int VTR_VID_W      = 12;
  localparam int VTR_PRI_LSB    = 12;
  localparam int VTR_BPRI_LSB   = 15;
  localparam int VTR_PRI_W      = 3;
  localparam int VTR_UNTAG_LSB  = 12;
  localparam int VTR_MEMBER_LSB = 13;
  localparam int VTR_PORTS      = 3;
  localparam int VTR_ENTRIES    = 16;
  localparam int VTR_IDX_W      = 4;
  localparam logic [VTR_VID_W-1:0]   VTR_VID_NULL  = 12'h000;
  localparam logic [VTR_ENTRY_W-1:0] VTR_PVID_RST  = 18'h0_0001;
  localparam logic [VTR_ENTRY_W-1:0] VTR_ENTRY_RST = 18'h0_0000;

  // ----------------------------------------------------------------
  // Command and configuration fields
  // ----------------------------------------------------------------
  localparam int VTR_CMD_W       = 6;
  localparam int VTR_CMD_IDX_LSB = 0;
  localparam int VTR_CMD_SEL_BIT = 4;
  localparam int VTR_CMD_RD_BIT  = 5;
  localparam int VTR_CFG_W       = 7;
  localparam int VTR_CFG_DIS_BIT = 0;
  localparam int VTR_CFG_ADM_LSB = 1;
  localparam int VTR_CFG_HYB_LSB = 4;
  localparam int VTR_STS_PEND    = 0;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_CAPT} vtr_state_t;

endpackage

// file: vtr_mem_if.sv
// Link between the table controller and the VLAN table memory.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface vtr_mem_if;
  import vtr_pkg::*;
  logic                       sw_wr;
  logic                       sw_rd;
  logic [VTR_IDX_W-1:0]       sw_idx;
  logic [VTR_ENTRY_W-1:0]     sw_wdata;
  logic [VTR_ENTRY_W-1:0]     sw_rdata;
  logic [VTR_VID_W-1:0]       lk_vid;
  logic                       lk_hit;
  logic [VTR_ENTRY_W-1:0]     lk_entry;

  modport ctl (output sw_wr, sw_rd, sw_idx, sw_wdata, lk_vid,
               input  sw_rdata, lk_hit, lk_entry);
  modport mem (input  sw_wr, sw_rd, sw_idx, sw_wdata, lk_vid,
               output sw_rdata, lk_hit, lk_entry);
endinterface

// file: vtr_vlan_mem.sv
// Sixteen-entry VLAN table with a software port and a VID match port.
// Assumes strobes are one-cycle pulses; both read results come from registers.
`timescale 1ns/10ps
module vtr_vlan_mem
  import vtr_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Controller side
  vtr_mem_if.mem    mif
);

  typedef struct packed {
    logic [VTR_ENTRIES-1:0][VTR_ENTRY_W-1:0] ent;
    logic [VTR_ENTRY_W-1:0]                  rdata;
    logic                                    hit;
    logic [VTR_ENTRY_W-1:0]                  lk;
  } vtr_mem_st_t;

  vtr_mem_st_t st_r;
  vtr_mem_st_t st_nxt;
  logic [VTR_ENTRIES-1:0] match;

  // ----------------------------------------------------------------
  // Per-entry VID compare
  // ----------------------------------------------------------------
  // A null VID never matches, so disabled entries stay out of lookups
  for (genvar g = 0; g < VTR_ENTRIES; g++) begin : g_cmp
    assign match[g] = (st_r.ent[g][VTR_VID_LSB +: VTR_VID_W] == mif.lk_vid) &&
                      (mif.lk_vid != VTR_VID_NULL);
  end

  always_comb begin
    st_nxt     = st_r;
    st_nxt.hit = |match;
    st_nxt.lk  = VTR_ENTRY_RST;
    // Lowest matching entry wins when software left duplicates
    for (int i = VTR_ENTRIES - 1; i >= 0; i--) begin
      if (match[i]) begin
        st_nxt.lk = st_r.ent[i];
      end
    end
    if (mif.sw_rd) begin
      st_nxt.rdata = st_r.ent[mif.sw_idx];
    end
    if (mif.sw_wr) begin
      st_nxt.ent[mif.sw_idx] = mif.sw_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mif.sw_rdata = st_r.rdata;
  assign mif.lk_hit   = st_r.hit;
  assign mif.lk_entry = st_r.lk;

endmodule

// file: vtr_top.sv
// VLAN table read port: APB registers, table command engine and the
// per-frame VLAN classification that uses the tables.
// Assumes APB inputs and frame inputs are synchronous to pclk.
`timescale 1ns/10ps

// What this block does
// - Read-only result of last table read
// - Port default entry: VID in bits 11:0
// - Default priority in bits 14:12
// - Broadcast priority in bits 17:15
// - Untagged or null-VID frames take default VID
// - VLAN disable forces default VID everywhere
// - Default priority when no other source
// - Reset defaults: VID 1, priorities 0
// - VLAN entry: member, untag per port, VID
// - Member port accepts and joins broadcast
// - Non-member drops unless admit set
// - Untag plus hybrid port strips tag
// - Pending bit set during table operation
module vtr_top
  import vtr_pkg::*;
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [VTR_AW-1:0]      paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // Received frame header
  input  wire logic                   fr_valid,
  input  wire logic [1:0]             fr_port,
  input  wire logic                   fr_tagged,
  input  wire logic [VTR_VID_W-1:0]   fr_vid,
  input  wire logic                   fr_bcast,
  input  wire logic                   fr_pri_valid,
  input  wire logic [VTR_PRI_W-1:0]   fr_pri,
  // Classification result
  output logic                        cls_valid,
  output logic [1:0]                  cls_port,
  output logic [VTR_VID_W-1:0]        cls_vid,
  output logic [VTR_PRI_W-1:0]        cls_pri,
  output logic                        cls_accept,
  output logic [VTR_PORTS-1:0]        cls_egress_mask,
  output logic [VTR_PORTS-1:0]        cls_untag_mask
);

  typedef struct packed {
    logic                   v;
    logic [1:0]             port;
    logic [VTR_VID_W-1:0]   vid;
    logic [VTR_PRI_W-1:0]   pri;
  } vtr_stage_t;

  typedef struct packed {
    vtr_state_t                            state;
    logic                                  pending;
    logic [VTR_CMD_W-1:0]                  cmd;
    logic [VTR_ENTRY_W-1:0]                wdata;
    logic [VTR_ENTRY_W-1:0]                result;
    logic [VTR_PORTS-1:0][VTR_ENTRY_W-1:0] pvid;
    logic [VTR_CFG_W-1:0]                  cfg;
    logic                                  mem_wr;
    logic                                  mem_rd;
    logic                                  pready;
    logic                                  pslverr;
    logic [31:0]                           prdata;
    vtr_stage_t                            s1;
    vtr_stage_t                            s2;
    logic                                  c_valid;
    logic [1:0]                            c_port;
    logic [VTR_VID_W-1:0]                  c_vid;
    logic [VTR_PRI_W-1:0]                  c_pri;
    logic                                  c_accept;
    logic [VTR_PORTS-1:0]                  c_egress;
    logic [VTR_PORTS-1:0]                  c_untag;
  } vtr_st_t;

  vtr_st_t   st_r;
  vtr_st_t   st_nxt;
  vtr_mem_if mif ();

  logic                  setup_ph;
  logic                  access_done;
  logic                  mapped;
  logic [1:0]            in_port;
  logic [VTR_ENTRY_W-1:0] in_def;
  logic [VTR_IDX_W-1:0]  cmd_idx;
  logic                  cmd_idx_ok;

  // ----------------------------------------------------------------
  // Table memory
  // ----------------------------------------------------------------
  vtr_vlan_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .mif     (mif.mem)
  );

  assign mif.sw_wr    = st_r.mem_wr;
  assign mif.sw_rd    = st_r.mem_rd;
  assign mif.sw_idx   = st_r.cmd[VTR_CMD_IDX_LSB +: VTR_IDX_W];
  assign mif.sw_wdata = st_r.wdata;
  assign mif.lk_vid   = st_r.s1.vid;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  assign setup_ph    = psel && !penable && !st_r.pready;
  assign access_done = psel && penable && st_r.pready;
  assign mapped      = (paddr == VTR_ADDR_CMD) || (paddr == VTR_ADDR_WDATA) ||
                       (paddr == VTR_ADDR_RESULT) || (paddr == VTR_ADDR_STATUS) ||
                       (paddr == VTR_ADDR_CFG);
  // Port 3 does not exist; its default entry reads as port 0
  assign in_port     = (fr_port < 2'(VTR_PORTS)) ? fr_port : 2'b00;
  assign in_def      = st_r.pvid[in_port];
  assign cmd_idx     = st_r.cmd[VTR_CMD_IDX_LSB +: VTR_IDX_W];
  assign cmd_idx_ok  = cmd_idx < VTR_IDX_W'(VTR_PORTS);

  always_comb begin
    st_nxt         = st_r;
    st_nxt.mem_wr  = 1'b0;
    st_nxt.mem_rd  = 1'b0;
    st_nxt.pready  = 1'b0;

    // --------------------------------------------------------------
    // APB: answer prepared in setup, zero wait states in access
    // --------------------------------------------------------------
    if (setup_ph) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = !mapped;
      st_nxt.prdata  = '0;
      if (!pwrite) begin
        case (paddr)
          VTR_ADDR_CMD:    st_nxt.prdata = 32'(st_r.cmd);
          VTR_ADDR_WDATA:  st_nxt.prdata = 32'(st_r.wdata);
          VTR_ADDR_RESULT: st_nxt.prdata = 32'(st_r.result);
          VTR_ADDR_STATUS: st_nxt.prdata = 32'(st_r.pending);
          VTR_ADDR_CFG:    st_nxt.prdata = 32'(st_r.cfg);
          default:         st_nxt.prdata = '0;
        endcase
      end
    end

    // Writes to the result and status words are dropped on purpose
    if (access_done && pwrite && !st_r.pslverr) begin
      case (paddr)
        VTR_ADDR_WDATA: st_nxt.wdata = pwdata[VTR_ENTRY_W-1:0];
        VTR_ADDR_CFG:   st_nxt.cfg   = pwdata[VTR_CFG_W-1:0];
        VTR_ADDR_CMD: begin
          // A command issued while one is pending is ignored
          if (!st_r.pending) begin
            st_nxt.cmd     = pwdata[VTR_CMD_W-1:0];
            st_nxt.pending = 1'b1;
            st_nxt.state   = ST_ISSUE;
          end
        end
        default: ;
      endcase
    end

    // --------------------------------------------------------------
    // Table command engine
    // --------------------------------------------------------------
    case (st_r.state)
      ST_IDLE: ;
      ST_ISSUE: begin
        if (st_r.cmd[VTR_CMD_RD_BIT]) begin
          if (st_r.cmd[VTR_CMD_SEL_BIT]) begin
            // Port default entry: VID, priority, broadcast priority
            st_nxt.result  = cmd_idx_ok ? st_r.pvid[cmd_idx[1:0]]
                                        : VTR_ENTRY_RST;
            st_nxt.pending = 1'b0;
            st_nxt.state   = ST_IDLE;
          end else begin
            st_nxt.mem_rd  = 1'b1;
            st_nxt.state   = ST_WAIT;
          end
        end else begin
          if (st_r.cmd[VTR_CMD_SEL_BIT]) begin
            if (cmd_idx_ok) begin
              st_nxt.pvid[cmd_idx[1:0]] = st_r.wdata;
            end
          end else begin
            st_nxt.mem_wr = 1'b1;
          end
          st_nxt.pending = 1'b0;
          st_nxt.state   = ST_IDLE;
        end
      end
      ST_WAIT: st_nxt.state = ST_CAPT;
      ST_CAPT: begin
        st_nxt.result  = mif.sw_rdata;
        st_nxt.pending = 1'b0;
        st_nxt.state   = ST_IDLE;
      end
      default: st_nxt.state = ST_IDLE;
    endcase

    // --------------------------------------------------------------
    // Frame stage 1: resolve VID and priority
    // --------------------------------------------------------------
    st_nxt.s1.v    = fr_valid && (fr_port < 2'(VTR_PORTS));
    st_nxt.s1.port = in_port;
    if (st_r.cfg[VTR_CFG_DIS_BIT] || !fr_tagged || fr_vid == VTR_VID_NULL) begin
      st_nxt.s1.vid = in_def[VTR_VID_LSB +: VTR_VID_W];
    end else begin
      st_nxt.s1.vid = fr_vid;
    end
    if (fr_bcast) begin
      st_nxt.s1.pri = in_def[VTR_BPRI_LSB +: VTR_PRI_W];
    end else if (fr_pri_valid) begin
      st_nxt.s1.pri = fr_pri;
    end else begin
      st_nxt.s1.pri = in_def[VTR_PRI_LSB +: VTR_PRI_W];
    end

    // Stage 2 waits one cycle for the table match
    st_nxt.s2 = st_r.s1;

    // --------------------------------------------------------------
    // Frame stage 3: membership and tag removal
    // --------------------------------------------------------------
    st_nxt.c_valid  = st_r.s2.v;
    st_nxt.c_port   = st_r.s2.port;
    st_nxt.c_vid    = st_r.s2.vid;
    st_nxt.c_pri    = st_r.s2.pri;
    for (int p = 0; p < VTR_PORTS; p++) begin
      st_nxt.c_egress[p] = mif.lk_hit && mif.lk_entry[VTR_MEMBER_LSB + 2*p];
      st_nxt.c_untag[p]  = mif.lk_hit && mif.lk_entry[VTR_UNTAG_LSB + 2*p] &&
                           st_r.cfg[VTR_CFG_HYB_LSB + p];
    end
    st_nxt.c_accept = st_nxt.c_egress[st_r.s2.port] ||
                      st_r.cfg[VTR_CFG_ADM_LSB + 32'(st_r.s2.port)];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.state    <= ST_IDLE;
      st_r.pvid     <= {VTR_PORTS{VTR_PVID_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready          = st_r.pready;
  assign prdata          = st_r.prdata;
  assign pslverr         = st_r.pslverr;
  assign cls_valid       = st_r.c_valid;
  assign cls_port        = st_r.c_port;
  assign cls_vid         = st_r.c_vid;
  assign cls_pri         = st_r.c_pri;
  assign cls_accept      = st_r.c_accept;
  assign cls_egress_mask = st_r.c_egress;
  assign cls_untag_mask  = st_r.c_untag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [VTR_ENTRY_W-1:0] chk_pvid_sel;
  assign chk_pvid_sel = cmd_idx_ok ? st_r.pvid[cmd_idx[1:0]] : VTR_ENTRY_RST;

  // Admit bit picked by the result's own port, not by the port of the cycle before
  logic [VTR_CFG_W-1:0]   chk_adm_mask;
  assign chk_adm_mask = VTR_CFG_W'(1) << (VTR_CFG_ADM_LSB + 32'(cls_port));

  upper_zero_a: assert property (
    psel && penable && pready && !pwrite && paddr == VTR_ADDR_RESULT
    |-> prdata[31:VTR_ENTRY_W] == '0)
    else $error("result upper bits not zero");

  result_ro_a: assert property (
    access_done && pwrite && paddr == VTR_ADDR_RESULT && !st_r.pending
    |=> $stable(st_r.result))
    else $error("write changed the result register");

  pend_done_a: assert property (
    $rose(st_r.pending) |-> ##[1:3] !st_r.pending)
    else $error("pending did not clear in time");

  pvid_read_a: assert property (
    st_r.state == ST_ISSUE && st_r.cmd[VTR_CMD_RD_BIT] && st_r.cmd[VTR_CMD_SEL_BIT]
    |=> st_r.result == $past(chk_pvid_sel) && !st_r.pending)
    else $error("port default read returned wrong entry");

  untag_vid_a: assert property (
    fr_valid && fr_port != 2'b11 && !fr_tagged
    |-> ##3 cls_valid && cls_vid == $past(in_def[VTR_VID_LSB +: VTR_VID_W], 3))
    else $error("untagged frame did not get default VID");

  disable_vid_a: assert property (
    fr_valid && fr_port != 2'b11 && st_r.cfg[VTR_CFG_DIS_BIT]
    |-> ##3 cls_vid == $past(in_def[VTR_VID_LSB +: VTR_VID_W], 3))
    else $error("VLAN disable did not force default VID");

  default_pri_a: assert property (
    fr_valid && fr_port != 2'b11 && !fr_bcast && !fr_pri_valid
    |-> ##3 cls_pri == $past(in_def[VTR_PRI_LSB +: VTR_PRI_W], 3))
    else $error("default priority not applied");

  bcast_pri_a: assert property (
    fr_valid && fr_port != 2'b11 && fr_bcast
    |-> ##3 cls_pri == $past(in_def[VTR_BPRI_LSB +: VTR_PRI_W], 3))
    else $error("broadcast priority not applied");

  nonmember_drop_a: assert property (
    cls_valid && !cls_egress_mask[cls_port] && ($past(st_r.cfg) & chk_adm_mask) == '0
    |-> !cls_accept)
    else $error("non-member frame accepted");

  member_accept_a: assert property (
    cls_valid && cls_egress_mask[cls_port]
    |-> cls_accept)
    else $error("member frame not accepted");

  untag_hybrid_a: assert property (
    cls_valid
    |-> (cls_untag_mask & ~$past(st_r.cfg[VTR_CFG_HYB_LSB +: VTR_PORTS])) == '0)
    else $error("tag stripped on a port that is not hybrid");

  vlan_read_a: assert property (
    st_r.state == ST_CAPT
    |=> st_r.result == $past(mif.sw_rdata) && !st_r.pending)
    else $error("table read did not load the result");

  vlan_read_c: cover property (
    st_r.state == ST_CAPT ##1 !st_r.pending);
  pvid_read_c: cover property (
    st_r.state == ST_ISSUE && st_r.cmd[VTR_CMD_SEL_BIT] && st_r.cmd[VTR_CMD_RD_BIT]);
  frame_drop_c: cover property (cls_valid && !cls_accept);
  tag_strip_c: cover property (cls_valid && |cls_untag_mask);

endmodule

// file: vtr_top_bench.sv
// Self-checking bench for the VLAN table read port: APB register access,
// table commands and the frame classification path.
// Assumes vtr_pkg and the design files are compiled first; one 10 MHz clock.
`timescale 1ns/10ps
module vtr_top_bench;
  import vtr_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [VTR_AW-1:0]      paddr;
  logic [31:0]            pwdata;
  logic                   pready;
  logic [31:0]            prdata;
  logic                   pslverr;
  logic                   fr_valid;
  logic [1:0]             fr_port;
  logic                   fr_tagged;
  logic [VTR_VID_W-1:0]   fr_vid;
  logic                   fr_bcast;
  logic                   fr_pri_valid;
  logic [VTR_PRI_W-1:0]   fr_pri;
  logic                   cls_valid;
  logic [1:0]             cls_port;
  logic [VTR_VID_W-1:0]   cls_vid;
  logic [VTR_PRI_W-1:0]   cls_pri;
  logic                   cls_accept;
  logic [VTR_PORTS-1:0]   cls_egress_mask;
  logic [VTR_PORTS-1:0]   cls_untag_mask;
  int                     failures;
  int                     checked;
  logic [31:0]            rd;
  logic                   err;

  vtr_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .fr_valid(fr_valid), .fr_port(fr_port), .fr_tagged(fr_tagged),
    .fr_vid(fr_vid), .fr_bcast(fr_bcast), .fr_pri_valid(fr_pri_valid), .fr_pri(fr_pri),
    .cls_valid(cls_valid), .cls_port(cls_port), .cls_vid(cls_vid), .cls_pri(cls_pri),
    .cls_accept(cls_accept), .cls_egress_mask(cls_egress_mask),
    .cls_untag_mask(cls_untag_mask));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The request stands until pready is sampled high at a rising edge; data are taken there
  task automatic apb(input logic wr, input logic [VTR_AW-1:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h0000_0001, {31'h0000_0000, pready});
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [VTR_AW-1:0] a,
                        input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
    chk("read error flag", 32'h0000_0000, {31'h0000_0000, err});
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    rd = 32'h0000_0001;
    while (rd[VTR_STS_PEND] !== 1'b0 && n < 10) begin
      n++;
      apb(1'b0, VTR_ADDR_STATUS, 32'h0000_0000);
    end
    chk("pending cleared", 32'h0000_0000, {31'h0000_0000, rd[VTR_STS_PEND]});
  endtask

  task automatic tbl(input logic rdc, input logic sel, input logic [3:0] idx);
    apb(1'b1, VTR_ADDR_CMD, {26'h000_0000, rdc, sel, idx});
    wait_idle();
  endtask

  function automatic logic [31:0] pack(input logic [1:0] port, input logic acc,
    input logic [2:0] eg, input logic [2:0] ut, input logic [2:0] pri, input logic [11:0] vid);
    return {7'h00, port, 1'b1, acc, eg, ut, pri, vid};
  endfunction

  // Classification result is checked in the one cycle that its pulse stands
  task automatic frame(input logic [1:0] port, input logic tag, input logic [11:0] vid,
                       input logic bc, input logic pv, input logic [2:0] pri,
                       input logic [31:0] exp);
    @(posedge pclk);
    fr_valid     <= 1'b1;
    fr_port      <= port;
    fr_tagged    <= tag;
    fr_vid       <= vid;
    fr_bcast     <= bc;
    fr_pri_valid <= pv;
    fr_pri       <= pri;
    @(posedge pclk);
    fr_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    if (cls_valid === 1'b1) begin
      chk("classification", exp, pack(cls_port, cls_accept, cls_egress_mask,
          cls_untag_mask, cls_pri, cls_vid));
    end else begin
      chk("classification", exp, {31'h0000_0000, cls_valid});
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // A few hundred cycles are expected; twenty thousand means a hang
  initial begin
    #2000000;
    failures++;
    complete_run();
  end

  initial begin
    failures = 0;
    checked  = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; fr_valid = 1'b0; fr_port = 2'b00; fr_tagged = 1'b0;
    fr_vid = '0; fr_bcast = 1'b0; fr_pri_valid = 1'b0; fr_pri = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("result at reset", VTR_ADDR_RESULT, 32'h0000_0000);
    rd_chk("status at reset", VTR_ADDR_STATUS, 32'h0000_0000);
    for (int p = 0; p < 3; p++) begin
      tbl(1'b1, 1'b1, 4'(p));
      rd_chk("default entry", VTR_ADDR_RESULT, 32'h0000_0001);
    end
    // Port 1: VID 055, priority 5, broadcast priority 3
    apb(1'b1, VTR_ADDR_WDATA, 32'h0001_D055);
    tbl(1'b0, 1'b1, 4'h1);
    tbl(1'b1, 1'b1, 4'h1);
    rd_chk("port 1 default", VTR_ADDR_RESULT, 32'h0001_D055);
    apb(1'b1, VTR_ADDR_RESULT, 32'hFFFF_FFFF);
    rd_chk("result after write", VTR_ADDR_RESULT, 32'h0001_D055);
    // Default VID FFE: all ones is reserved and stays unused
    apb(1'b1, VTR_ADDR_WDATA, 32'hFFFF_FFFE);
    tbl(1'b0, 1'b1, 4'h2);
    tbl(1'b1, 1'b1, 4'h2);
    rd_chk("upper bits", VTR_ADDR_RESULT, 32'h0003_FFFE);
    // VLAN entry 0: VID 123, members 0 and 1, untag on port 1
    apb(1'b1, VTR_ADDR_WDATA, 32'h0000_E123);
    tbl(1'b0, 1'b0, 4'h0);
    apb(1'b1, VTR_ADDR_CMD, 32'h0000_0020);
    rd_chk("pending during read", VTR_ADDR_STATUS, 32'h0000_0001);
    wait_idle();
    rd_chk("vlan entry", VTR_ADDR_RESULT, 32'h0000_E123);
    tbl(1'b1, 1'b0, 4'h5);
    rd_chk("empty vlan entry", VTR_ADDR_RESULT, 32'h0000_0000);
    apb(1'b0, 16'h0000, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
    chk("unmapped data", 32'h0000_0000, rd);
    // Hybrid egress on port 1, admit non-members on port 2
    apb(1'b1, VTR_ADDR_CFG, 32'h0000_0028);
    frame(2'd0, 1'b0, 12'h123, 1'b0, 1'b0, 3'd6,
          pack(2'd0, 1'b0, 3'b000, 3'b000, 3'd0, 12'h001));
    frame(2'd1, 1'b1, 12'h123, 1'b0, 1'b1, 3'd6,
          pack(2'd1, 1'b1, 3'b011, 3'b010, 3'd6, 12'h123));
    frame(2'd1, 1'b1, 12'h123, 1'b1, 1'b1, 3'd6,
          pack(2'd1, 1'b1, 3'b011, 3'b010, 3'd3, 12'h123));
    frame(2'd1, 1'b1, 12'h000, 1'b0, 1'b0, 3'd6,
          pack(2'd1, 1'b0, 3'b000, 3'b000, 3'd5, 12'h055));
    frame(2'd2, 1'b1, 12'h123, 1'b0, 1'b0, 3'd1,
          pack(2'd2, 1'b1, 3'b011, 3'b010, 3'd7, 12'h123));
    frame(2'd3, 1'b1, 12'h123, 1'b0, 1'b0, 3'd1, 32'h0000_0000);
    apb(1'b1, VTR_ADDR_CFG, 32'h0000_0029);
    frame(2'd1, 1'b1, 12'h123, 1'b0, 1'b0, 3'd6,
          pack(2'd1, 1'b0, 3'b000, 3'b000, 3'd5, 12'h055));
    complete_run();
  end
endmodule
